/* File: hw/pattern_pkg.sv */
package pattern_pkg;

  // sizes of the pattern output
  localparam int GROUPS = 4;
  localparam int GROUP_W = 4;
  localparam int CHANNELS = 4;
  localparam int SEL_W = 2;
  localparam int REG_W = 8;
  localparam int OUT_W = GROUPS * GROUP_W;

  // avalon side
  localparam int BUS_DATA_W = 32;
  localparam int BUS_ADDR_W = 18;
  localparam int BUS_BE_W = 4;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 16;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_MODE = 16'hffa0;
  localparam logic [IDX_W-1:0] IDX_CTRL = 16'hffa1;
  localparam logic [IDX_W-1:0] IDX_ENA_HI = 16'hffa2;
  localparam logic [IDX_W-1:0] IDX_ENA_LO = 16'hffa3;
  localparam logic [IDX_W-1:0] IDX_NDR_HI = 16'hffa4;
  localparam logic [IDX_W-1:0] IDX_NDR_LO = 16'hffa5;
  localparam logic [IDX_W-1:0] IDX_NDR_HI_ALT = 16'hffa6;
  localparam logic [IDX_W-1:0] IDX_NDR_LO_ALT = 16'hffa7;
  localparam logic [IDX_W-1:0] IDX_DIR_A = 16'hffd1;
  localparam logic [IDX_W-1:0] IDX_DATA_A = 16'hffd3;
  localparam logic [IDX_W-1:0] IDX_DIR_B = 16'hffd4;
  localparam logic [IDX_W-1:0] IDX_DATA_B = 16'hffd6;

  // reset and fixed read values
  localparam logic [REG_W-1:0] RST_MODE = 8'hf0;
  localparam logic [REG_W-1:0] RST_CTRL = 8'hff;
  localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
  localparam logic [REG_W-1:0] RD_RESERVED = 8'hff;
  localparam logic [GROUP_W-1:0] NIB_ONES = 4'hf;
  localparam logic [BUS_DATA_W-1:0] RD_UNMAPPED = 32'h0000_0000;
  localparam logic [BUS_DATA_W-REG_W-1:0] RD_PAD = 24'h00_0000;

  // field positions
  localparam int MODE_NOVL_LSB = 0;
  localparam int NIB_HI_LSB = 4;
  localparam int NIB_LO_LSB = 0;
  localparam int BE_LOW_LANE = 0;

  // bus handshake
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage

/* File: hw/trigger_select.sv */
`timescale 1ns/1ps
module trigger_select
  import pattern_pkg::*;
(
  // channel choice
  input wire logic [pattern_pkg::SEL_W-1:0] sel,
  // compare match pulses of the timer
  input wire logic [pattern_pkg::CHANNELS-1:0] cmp_a,
  input wire logic [pattern_pkg::CHANNELS-1:0] cmp_b,
  // chosen trigger pulses
  output logic fire_a,
  output logic fire_b
);

  ////////////////////////////////////////////////////////////////////////////
  // one of four channels picks the group trigger
  assign fire_a = cmp_a[sel];
  assign fire_b = cmp_b[sel];

endmodule

/* File: hw/group_update.sv */
`timescale 1ns/1ps
module group_update
  import pattern_pkg::*;
(
  // present state of this group
  input wire logic [pattern_pkg::GROUP_W-1:0] cur,
  input wire logic [pattern_pkg::GROUP_W-1:0] next_bits,
  input wire logic [pattern_pkg::GROUP_W-1:0] enable,
  // trigger and mode
  input wire logic fire_a,
  input wire logic fire_b,
  input wire logic non_overlap,
  // software write of the port data
  input wire logic sw_we,
  input wire logic [pattern_pkg::GROUP_W-1:0] sw_data,
  // next value of the group
  output logic [pattern_pkg::GROUP_W-1:0] nxt
);

  logic [GROUP_W-1:0] hw_val;
  logic [GROUP_W-1:0] sw_val;
  logic [GROUP_W-1:0] early_fall;

  ////////////////////////////////////////////////////////////////////////////
  // non-overlap: falling bits drop early on match b, rising bits wait for a
  assign early_fall = cur & next_bits;
  assign hw_val = fire_a ? next_bits : ((fire_b & non_overlap) ? early_fall : cur);
  // software only reaches bits not claimed by pattern output
  assign sw_val = sw_we ? sw_data : cur;
  assign nxt = (enable & hw_val) | (~enable & sw_val);

endmodule

/* File: hw/pattern_controller.sv */
`timescale 1ns/1ps
// Overview of operation
// - four independent nibble groups update simultaneously
// - sixteen outputs, each bit enabled separately
// - each group picks one of four channels
// - non-overlap mode guards between output changes
// - selected compare match A pulses also request dma transfers
// - outputs 0-3 group 0 ... 12-15 group 3
// - reset mode f0, control ff, others 00
// - low next data address follows group 0/1 triggers
// - high next data address follows group 2/3 triggers
// - enabled port data bits ignore software writes
// - port a direction is write-only, per pin
// - port a data reads current group 0/1 outputs
// - decode address bits 17:2 only, bits 1:0 ignored
// - selected match A copies next data to port
// - reserved next data nibbles read ones
// - next data cleared in reset and standby
module pattern_controller
  import pattern_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // avalon-mm slave
  input wire logic [pattern_pkg::BUS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [pattern_pkg::BUS_DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [pattern_pkg::BUS_BE_W-1:0] AVS_BYTEENABLE,
  output logic [pattern_pkg::BUS_DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // timer compare match pulses, one per channel
  input wire logic [pattern_pkg::CHANNELS-1:0] COMPARE_A,
  input wire logic [pattern_pkg::CHANNELS-1:0] COMPARE_B,
  // hardware standby level
  input wire logic HW_STANDBY,
  // pattern pins and dma requests
  output logic [pattern_pkg::OUT_W-1:0] PATTERN_OUT,
  output logic [pattern_pkg::OUT_W-1:0] PATTERN_OE,
  output logic [pattern_pkg::CHANNELS-1:0] DMA_REQ
);

  import pattern_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // next data read with reserved nibbles forced to ones
  function automatic logic [REG_W-1:0] ndr_read(input logic same, input logic [REG_W-1:0] val,
                                                input logic primary);
    logic [REG_W-1:0] r;
    r = RD_RESERVED;
    if (same) begin
      r = primary ? val : RD_RESERVED;
    end else if (primary) begin
      r = {val[NIB_HI_LSB +: GROUP_W], NIB_ONES};
    end else begin
      r = {NIB_ONES, val[NIB_LO_LSB +: GROUP_W]};
    end
    return r;
  endfunction

  // next data write, reserved nibbles keep their value
  function automatic logic [REG_W-1:0] ndr_write(input logic same, input logic [REG_W-1:0] cur,
                                                 input logic [REG_W-1:0] data,
                                                 input logic primary);
    logic [REG_W-1:0] r;
    r = cur;
    if (same) begin
      r = primary ? data : cur;
    end else if (primary) begin
      r = {data[NIB_HI_LSB +: GROUP_W], cur[NIB_LO_LSB +: GROUP_W]};
    end else begin
      r = {cur[NIB_HI_LSB +: GROUP_W], data[NIB_LO_LSB +: GROUP_W]};
    end
    return r;
  endfunction

  // true when any group takes its trigger from this channel
  function automatic logic chan_in_use(input logic [REG_W-1:0] ctrl, input int chan);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < GROUPS; k++) begin
      if (ctrl[k*SEL_W +: SEL_W] == SEL_W'(chan)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register state
  bus_state_e state_ff, nxt_state;
  logic waitreq_ff;
  logic [BUS_DATA_W-1:0] readdata_ff;
  logic [GROUP_W-1:0] novl_ff;
  logic [REG_W-1:0] ctrl_ff;
  logic [REG_W-1:0] ena_hi_ff;
  logic [REG_W-1:0] ena_lo_ff;
  logic [REG_W-1:0] ndr_hi_ff;
  logic [REG_W-1:0] ndr_lo_ff;
  logic [REG_W-1:0] dir_a_ff;
  logic [REG_W-1:0] dir_b_ff;
  logic [OUT_W-1:0] pattern_ff;
  logic [CHANNELS-1:0] dma_ff;

  logic [REG_W-1:0] nxt_ndr_hi;
  logic [REG_W-1:0] nxt_ndr_lo;
  logic [OUT_W-1:0] nxt_pattern;
  logic [CHANNELS-1:0] nxt_dma;

  ////////////////////////////////////////////////////////////////////////////
  // address decode on the word index, byte address bits 1:0 ignored
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr_go;
  logic hit_mode, hit_ctrl, hit_ena_hi, hit_ena_lo;
  logic hit_ndr_hi, hit_ndr_lo, hit_ndr_hi_alt, hit_ndr_lo_alt;
  logic hit_dir_a, hit_dir_b, hit_data_a, hit_data_b;
  logic [REG_W-1:0] wdata;

  assign idx = AVS_ADDRESS[IDX_LSB +: IDX_W];
  assign req = AVS_READ | AVS_WRITE;
  // a write lands only at the edge that sees waitrequest low
  assign wr_go = AVS_WRITE & (state_ff == BUS_ACK) & AVS_BYTEENABLE[BE_LOW_LANE];
  assign wdata = AVS_WRITEDATA[REG_W-1:0];
  assign hit_mode = (idx == IDX_MODE);
  assign hit_ctrl = (idx == IDX_CTRL);
  assign hit_ena_hi = (idx == IDX_ENA_HI);
  assign hit_ena_lo = (idx == IDX_ENA_LO);
  assign hit_ndr_hi = (idx == IDX_NDR_HI);
  assign hit_ndr_lo = (idx == IDX_NDR_LO);
  assign hit_ndr_hi_alt = (idx == IDX_NDR_HI_ALT);
  assign hit_ndr_lo_alt = (idx == IDX_NDR_LO_ALT);
  assign hit_dir_a = (idx == IDX_DIR_A);
  assign hit_dir_b = (idx == IDX_DIR_B);
  assign hit_data_a = (idx == IDX_DATA_A);
  assign hit_data_b = (idx == IDX_DATA_B);

  // write strobes, one per register, only at the landing edge
  logic we_mode, we_ctrl, we_ena_hi, we_ena_lo, we_dir_a, we_dir_b;
  logic we_ndr_hi, we_ndr_lo, we_ndr_hi_alt, we_ndr_lo_alt, we_data_a, we_data_b;

  assign we_mode = wr_go & hit_mode;
  assign we_ctrl = wr_go & hit_ctrl;
  assign we_ena_hi = wr_go & hit_ena_hi;
  assign we_ena_lo = wr_go & hit_ena_lo;
  assign we_dir_a = wr_go & hit_dir_a;
  assign we_dir_b = wr_go & hit_dir_b;
  assign we_ndr_hi = wr_go & hit_ndr_hi;
  assign we_ndr_lo = wr_go & hit_ndr_lo;
  assign we_ndr_hi_alt = wr_go & hit_ndr_hi_alt;
  assign we_ndr_lo_alt = wr_go & hit_ndr_lo_alt;
  assign we_data_a = wr_go & hit_data_a;
  assign we_data_b = wr_go & hit_data_b;

  ////////////////////////////////////////////////////////////////////////////
  // group trigger choices and shared-trigger detection
  logic [SEL_W-1:0] grp_sel [GROUPS];
  logic same_lo;
  logic same_hi;

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_sel
      assign grp_sel[g] = ctrl_ff[g*SEL_W +: SEL_W];
    end
  endgenerate

  assign same_lo = (grp_sel[0] == grp_sel[1]);
  assign same_hi = (grp_sel[2] == grp_sel[3]);

  ////////////////////////////////////////////////////////////////////////////
  // read data mux; direction registers are write-only and read zero
  logic [REG_W-1:0] rd_byte;
  logic rd_hit;
  logic [REG_W-1:0] rd_ndr_hi, rd_ndr_hi_alt, rd_ndr_lo, rd_ndr_lo_alt;

  // next data views; with two triggers in a pair the alternate address holds the other nibble
  assign rd_ndr_hi = ndr_read(same_hi, ndr_hi_ff, 1'b1);
  assign rd_ndr_hi_alt = ndr_read(same_hi, ndr_hi_ff, 1'b0);
  assign rd_ndr_lo = ndr_read(same_lo, ndr_lo_ff, 1'b1);
  assign rd_ndr_lo_alt = ndr_read(same_lo, ndr_lo_ff, 1'b0);

  assign rd_byte =
    hit_mode ? {NIB_ONES, novl_ff} :
    hit_ctrl ? ctrl_ff :
    hit_ena_hi ? ena_hi_ff :
    hit_ena_lo ? ena_lo_ff :
    hit_ndr_hi ? rd_ndr_hi :
    hit_ndr_hi_alt ? rd_ndr_hi_alt :
    hit_ndr_lo ? rd_ndr_lo :
    hit_ndr_lo_alt ? rd_ndr_lo_alt :
    hit_data_a ? pattern_ff[REG_W-1:0] :
    hit_data_b ? pattern_ff[OUT_W-1:REG_W] :
    RST_ZERO;
  assign rd_hit = hit_mode | hit_ctrl | hit_ena_hi | hit_ena_lo | hit_ndr_hi | hit_ndr_lo |
                  hit_ndr_hi_alt | hit_ndr_lo_alt | hit_dir_a | hit_dir_b |
                  hit_data_a | hit_data_b;

  ////////////////////////////////////////////////////////////////////////////
  // one wait cycle per access keeps readdata a plain register
  always_comb begin
    nxt_state = BUS_IDLE;
    case (state_ff)
      BUS_IDLE: begin
        nxt_state = req ? BUS_ACK : BUS_IDLE;
      end
      BUS_ACK: begin
        nxt_state = BUS_IDLE;
      end
      default: begin
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  // read data is caught at the taking edge, a later match shows next read
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= BUS_IDLE;
      waitreq_ff <= 1'b1;
      readdata_ff <= RD_UNMAPPED;
    end else begin
      state_ff <= nxt_state;
      waitreq_ff <= !(nxt_state == BUS_ACK);
      if (state_ff == BUS_IDLE && req) begin
        readdata_ff <= rd_hit ? {RD_PAD, rd_byte} : RD_UNMAPPED;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers written by software
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      novl_ff <= RST_MODE[GROUP_W-1:0];
      ctrl_ff <= RST_CTRL;
      ena_hi_ff <= RST_ZERO;
      ena_lo_ff <= RST_ZERO;
      dir_a_ff <= RST_ZERO;
      dir_b_ff <= RST_ZERO;
    end else begin
      if (we_mode) novl_ff <= wdata[MODE_NOVL_LSB +: GROUP_W];
      if (we_ctrl) ctrl_ff <= wdata;
      if (we_ena_hi) ena_hi_ff <= wdata;
      if (we_ena_lo) ena_lo_ff <= wdata;
      if (we_dir_a) dir_a_ff <= wdata;
      if (we_dir_b) dir_b_ff <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next data: split addressing when a pair of groups has two triggers
  always_comb begin
    nxt_ndr_hi = ndr_hi_ff;
    nxt_ndr_lo = ndr_lo_ff;
    if (HW_STANDBY) begin
      nxt_ndr_hi = RST_ZERO;
      nxt_ndr_lo = RST_ZERO;
    end else begin
      if (we_ndr_hi) nxt_ndr_hi = ndr_write(same_hi, ndr_hi_ff, wdata, 1'b1);
      if (we_ndr_hi_alt) nxt_ndr_hi = ndr_write(same_hi, ndr_hi_ff, wdata, 1'b0);
      if (we_ndr_lo) nxt_ndr_lo = ndr_write(same_lo, ndr_lo_ff, wdata, 1'b1);
      if (we_ndr_lo_alt) nxt_ndr_lo = ndr_write(same_lo, ndr_lo_ff, wdata, 1'b0);
    end
  end

  // software standby is not an input: contents simply stay
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ndr_hi_ff <= RST_ZERO;
      ndr_lo_ff <= RST_ZERO;
    end else begin
      ndr_hi_ff <= nxt_ndr_hi;
      ndr_lo_ff <= nxt_ndr_lo;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-group trigger and update, all four in parallel
  logic [OUT_W-1:0] ena_all;
  logic [OUT_W-1:0] ndr_all;
  logic [GROUPS-1:0] fire_a;
  logic [GROUPS-1:0] fire_b;

  assign ena_all = {ena_hi_ff, ena_lo_ff};
  assign ndr_all = {ndr_hi_ff, ndr_lo_ff};

  generate
    for (g = 0; g < GROUPS; g++) begin : g_grp
      logic sw_we;
      // groups 0 and 1 live in port a, groups 2 and 3 in port b
      assign sw_we = (g < GROUPS / 2) ? we_data_a : we_data_b;
      trigger_select u_trig (
        .sel(grp_sel[g]),
        .cmp_a(COMPARE_A),
        .cmp_b(COMPARE_B),
        .fire_a(fire_a[g]),
        .fire_b(fire_b[g])
      );
      group_update u_upd (
        .cur(pattern_ff[g*GROUP_W +: GROUP_W]),
        .next_bits(ndr_all[g*GROUP_W +: GROUP_W]),
        .enable(ena_all[g*GROUP_W +: GROUP_W]),
        .fire_a(fire_a[g]),
        .fire_b(fire_b[g]),
        .non_overlap(novl_ff[g]),
        .sw_we(sw_we),
        .sw_data(wdata[(g % 2)*GROUP_W +: GROUP_W]),
        .nxt(nxt_pattern[g*GROUP_W +: GROUP_W])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // dma request for each channel that triggers some group
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++) begin : g_dma
      assign nxt_dma[c] = COMPARE_A[c] & chan_in_use(ctrl_ff, c);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // output flops; the match pulse edge loads them, seen next cycle
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pattern_ff <= {RST_ZERO, RST_ZERO};
      dma_ff <= {CHANNELS{1'b0}};
    end else begin
      pattern_ff <= nxt_pattern;
      dma_ff <= nxt_dma;
    end
  end

  // pins drive only where software set the direction bit
  assign PATTERN_OUT = pattern_ff;
  assign PATTERN_OE = {dir_b_ff, dir_a_ff};
  assign DMA_REQ = dma_ff;
  assign AVS_READDATA = readdata_ff;
  assign AVS_WAITREQUEST = waitreq_ff;

endmodule

/* File: tb/timer_model.sv */
`timescale 1ns/1ps
// stand-in for the timer: one-cycle compare pulses on request
module timer_model
  import pattern_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pulse requests from the bench
  input wire logic [pattern_pkg::CHANNELS-1:0] go_a,
  input wire logic [pattern_pkg::CHANNELS-1:0] go_b,
  // compare match pulses
  output logic [pattern_pkg::CHANNELS-1:0] cmp_a,
  output logic [pattern_pkg::CHANNELS-1:0] cmp_b
);
  // registered, so pulses leave just after an edge as real timer flops do
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a <= '0;
      cmp_b <= '0;
    end else begin
      cmp_a <= go_a;
      cmp_b <= go_b;
    end
  end
endmodule

/* File: tb/pattern_properties.sv */
`timescale 1ns/1ps
module pattern_checker
  import pattern_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  // register bus
  input wire logic [pattern_pkg::BUS_ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [pattern_pkg::BUS_DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [pattern_pkg::BUS_BE_W-1:0] AVS_BYTEENABLE,
  input wire logic [pattern_pkg::BUS_DATA_W-1:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // timer and pins
  input wire logic [pattern_pkg::CHANNELS-1:0] COMPARE_A,
  input wire logic [pattern_pkg::CHANNELS-1:0] COMPARE_B,
  input wire logic HW_STANDBY,
  input wire logic [pattern_pkg::OUT_W-1:0] PATTERN_OUT,
  input wire logic [pattern_pkg::OUT_W-1:0] PATTERN_OE,
  input wire logic [pattern_pkg::CHANNELS-1:0] DMA_REQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  // helpers: register index and causes of a pin change
  wire [IDX_W-1:0] idx;
  wire wdone;
  wire cause;
  assign idx = AVS_ADDRESS[17:2];
  assign wdone = AVS_WRITE && !AVS_WAITREQUEST;
  assign cause = (COMPARE_A != 4'h0) || (COMPARE_B != 4'h0) || wdone;
  // bus steps: request taken, then a single answer cycle
  sequence s_taken;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_rd_done;
    AVS_READ && !AVS_WAITREQUEST;
  endsequence
  a_req_answered: assert property (s_taken |-> ##[1:2] !AVS_WAITREQUEST)
    else $error("bus request not answered");
  a_ack_one_cycle: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  a_ack_has_req: assert property (!AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
    else $error("answer without request");
  a_read_pad: assert property (s_rd_done |-> AVS_READDATA[31:8] == RD_PAD)
    else $error("read data upper bytes not zero");
  a_mode_upper: assert property (s_rd_done ##0 idx == IDX_MODE |-> AVS_READDATA[7:4] == 4'hf)
    else $error("mode upper nibble not ones");
  a_dma_cause: assert property (DMA_REQ != 4'h0 |-> (DMA_REQ & ~$past(COMPARE_A)) == 4'h0)
    else $error("dma request without compare match");
  a_out_cause: assert property ($changed(PATTERN_OUT) |-> $past(cause))
    else $error("pattern changed without trigger or write");
  a_oe_cause: assert property ($changed(PATTERN_OE) |-> $past(wdone))
    else $error("direction changed without write");
endmodule
bind pattern_controller pattern_checker pattern_checker_i (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .COMPARE_A(COMPARE_A),
  .COMPARE_B(COMPARE_B), .HW_STANDBY(HW_STANDBY), .PATTERN_OUT(PATTERN_OUT),
  .PATTERN_OE(PATTERN_OE), .DMA_REQ(DMA_REQ));

/* File: tb/timing_pattern_output_ctrl_tb_top.sv */
`timescale 1ns/1ps
module timing_pattern_output_ctrl_tb_top;
  import pattern_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [17:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = '0;
  logic [3:0] be = 4'h1;
  logic [31:0] rdat;
  logic wait_q;
  logic [3:0] go_a = 4'h0;
  logic [3:0] go_b = 4'h0;
  logic [3:0] cmpa, cmpb, dma;
  logic stby = 1'b0;
  logic [15:0] pout, poe;
  logic [31:0] st = 32'h89bd_5fd2;
  int err_total = 0;
  int tests_run = 0;
  logic [15:0] ri [10] = '{IDX_MODE, IDX_CTRL, IDX_ENA_HI, IDX_ENA_LO, IDX_NDR_HI,
    IDX_NDR_LO, IDX_DATA_A, IDX_DATA_B, IDX_DIR_A, IDX_DIR_B};
  logic [7:0] rv [10] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  pattern_controller pattern_controller_i (.CORE_CLK(clk), .ARST_N(rst_n), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_q), .COMPARE_A(cmpa), .COMPARE_B(cmpb),
    .HW_STANDBY(stby), .PATTERN_OUT(pout), .PATTERN_OE(poe), .DMA_REQ(dma));
  timer_model timer_model_i (.clk(clk), .rst_n(rst_n), .go_a(go_a), .go_b(go_b),
    .cmp_a(cmpa), .cmp_b(cmpb));
  ////////////////////////////////////////////////////////////////
  // verdict, reached from the main flow and from the watchdog
  task final_report;
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t pins got %h exp %h", $time, got, exp);
    end
  endtask
  // xorshift, fixed seed keeps runs repeatable
  function logic [7:0] rnd();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st[7:0];
  endfunction
  // enabled bits take nxt, the rest keep cur
  function logic [7:0] mix(input logic [7:0] cur, input logic [7:0] nxt, input logic [7:0] en);
    return (nxt & en) | (cur & ~en);
  endfunction
  // one bus access; request held until the answer edge, bounded wait
  task bus(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] b,
           output logic [7:0] q);
    int n;
    @(posedge clk);
    adr <= {idx, 2'b00};
    rd <= !w;
    wr <= w;
    wdat <= {24'h00_0000, d};
    be <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_q !== 1'b0 && n < 20);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_q !== 1'b0) begin
      err_total++;
      final_report;
    end
  endtask
  task wr8(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] b = 4'h1);
    logic [7:0] q;
    bus(1'b1, idx, d, b, q);
  endtask
  task rchk(input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, 4'h1, q);
    chk8(q, exp);
  endtask
  // timer pulse goes out one edge later, design takes it the edge after
  task fire(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk);
    go_a <= a;
    go_b <= b;
    @(posedge clk);
    go_a <= 4'h0;
    go_b <= 4'h0;
    @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog so a stuck run still ends with a verdict
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report;
  end
  // main sequence
  initial begin
    logic [7:0] nd, ndh, en, enh, v, ndl;
    logic [15:0] ex;
    ex = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rchk(ri[i], rv[i]);
    v = rnd();
    wr8(IDX_DIR_A, v);
    wr8(IDX_DIR_B, ~v);
    #1;
    chk16(poe, {~v, v});
    wr8(IDX_DIR_A, 8'hff);
    wr8(IDX_DIR_B, 8'hff);
    // random data, enables and port writes, all groups on one trigger
    repeat (6) begin
      nd = rnd();
      ndh = rnd();
      en = rnd();
      enh = rnd();
      v = rnd();
      wr8(IDX_ENA_LO, en);
      wr8(IDX_ENA_HI, enh);
      wr8(IDX_NDR_LO, nd);
      wr8(IDX_NDR_HI, ndh);
      wr8(IDX_DATA_A, v);
      ex[7:0] = mix(v, ex[7:0], en);
      rchk(IDX_DATA_A, ex[7:0]);
      fire(4'h8, 4'h0);
      ex = {mix(ex[15:8], ndh, enh), mix(ex[7:0], nd, en)};
      chk16(pout, ex);
      chk16({12'h000, dma}, 16'h0008);
    end
    // group 0 on its own channel: split next data addresses
    ndl = nd;
    wr8(IDX_ENA_LO, 8'hff);
    for (int c = 0; c < 3; c++) begin
      wr8(IDX_CTRL, 8'hfc | 8'(c));
      nd = rnd();
      v = rnd();
      wr8(IDX_NDR_LO_ALT, nd);
      wr8(IDX_NDR_LO, v);
      ndl = {v[7:4], nd[3:0]};
      rchk(IDX_NDR_LO, {ndl[7:4], 4'hf});
      rchk(IDX_NDR_LO_ALT, {4'hf, ndl[3:0]});
      fire(4'(1 << c), 4'h0);
      ex[3:0] = ndl[3:0];
      chk16(pout, ex);
      chk16({12'h000, dma}, 16'(1 << c));
    end
    wr8(IDX_CTRL, 8'hcf);
    rchk(IDX_NDR_HI, {ndh[7:4], 4'hf});
    rchk(IDX_NDR_HI_ALT, {4'hf, ndh[3:0]});
    wr8(IDX_CTRL, 8'hff);
    wr8(IDX_NDR_HI_ALT, 8'h00);
    rchk(IDX_NDR_HI_ALT, 8'hff);
    rchk(IDX_NDR_HI, ndh);
    // non-overlap on group 0: early fall on match B, full load on match A
    wr8(IDX_MODE, 8'h01);
    rchk(IDX_MODE, 8'hf1);
    nd = rnd();
    wr8(IDX_NDR_LO, nd);
    fire(4'h0, 4'h8);
    ex[3:0] = ex[3:0] & nd[3:0];
    chk16(pout, ex);
    chk16({12'h000, dma}, 16'h0000);
    fire(4'h8, 4'h0);
    ex = {mix(ex[15:8], ndh, enh), nd};
    chk16(pout, ex);
    wr8(IDX_MODE, 8'h00);
    // refused accesses leave state alone
    wr8(IDX_CTRL, 8'h00, 4'he);
    rchk(IDX_CTRL, 8'hff);
    wr8(16'hffa8, 8'h5a);
    rchk(16'hffa8, 8'h00);
    // standby clears next data, blocks its writes, spares the enables
    @(posedge clk);
    stby <= 1'b1;
    wr8(IDX_NDR_LO, 8'haa);
    stby <= 1'b0;
    rchk(IDX_NDR_LO, 8'h00);
    rchk(IDX_NDR_HI, 8'h00);
    rchk(IDX_ENA_LO, 8'hff);
    // second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk16(pout, 16'h0000);
    rchk(IDX_CTRL, 8'hff);
    final_report;
  end
endmodule
